// ===== rtl/pwr_regs.svh
`ifndef PWR_REGS_SVH
`define PWR_REGS_SVH
`define PCTL_ADDR          8'h87
`define PCTL_RESET         8'h00
`define PCTL_BAUD_DOUBLE   7
`define PCTL_AUX_RAM_DIS   6
`define PCTL_STROBE_SUPP   5
`define PCTL_WD_LOAD_EN    4
`define PCTL_GFLAG1        3
`define PCTL_GFLAG0        2
`define PCTL_POWER_DOWN    1
`define PCTL_IDLE          0
`define WD_RESTART_CYCLES  3
`define HF_RESET_CYCLES    24
`define CLK_PERIOD_NS      40
`define PLL_RESET_MIN_NS   1000
`define PLL_RESET_MAX_NS   10000000
`define PLL_RESTART_MS     63
`endif

// ===== rtl/pwr_pkg.sv
package pwr_pkg;
	typedef enum logic [1:0] {
		MODE_RUN   = 2'b00,
		MODE_IDLE  = 2'b01,
		MODE_PDOWN = 2'b11,
		MODE_WAKE  = 2'b10
	} mode_t;
endpackage

// ===== rtl/pwr_if.sv
`timescale 1ns/1ns
interface pwr_if;
	logic       sfr_wr;
	logic [7:0] sfr_addr;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;
	logic       wd_counter_load;
	logic       watchdog_enable_pin_n;
	logic       osc_source_select;
	logic       keep_slow_osc;
	logic       irq_in_service_block;
	logic       ext_irq0_wake;
	logic       ext_irq1_wake;
	logic       seconds_wake;
	logic       wake_irq_taken;
	logic       watchdog_reset;
	logic       core_halted;
	logic       idle_mode;
	logic       pdown_mode;
	modport device (
		input  sfr_wr, sfr_addr, sfr_wdata, wd_counter_load, watchdog_enable_pin_n, osc_source_select,
		       keep_slow_osc, irq_in_service_block, ext_irq0_wake, ext_irq1_wake, seconds_wake,
		       wake_irq_taken, watchdog_reset,
		output sfr_rdata, core_halted, idle_mode, pdown_mode
	);
	modport core (
		output sfr_wr, sfr_addr, sfr_wdata, wd_counter_load, watchdog_enable_pin_n, osc_source_select,
		       keep_slow_osc, irq_in_service_block, ext_irq0_wake, ext_irq1_wake, seconds_wake,
		       wake_irq_taken, watchdog_reset,
		input  sfr_rdata, core_halted, idle_mode, pdown_mode
	);
endinterface

// ===== rtl/power_mode_control.sv
`timescale 1ns/1ns
`include "pwr_regs.svh"
// Overview of operation
// - baud_double set doubles UART baud rate
// - aux_ram_disable routes data moves external
// - strobe_suppress stops strobe; reset clears it
// - Watchdog load enable cleared on counter load
// - power_down_bit accepted only when pin high
// - idle_bit write halts core into Idle
// - Register at 87H, resets to zero
// - Peripherals stay clocked during Idle
// - Idle entry resets timer2, PWM, ADC
// - Power-down halts clocks; slow osc optional
// - Strobes high Idle, low Power-down
// - I2C pins driven in Idle only if enabled
// - Core state frozen during Idle
// - Enabled interrupt clears idle_bit, exits Idle
// - External reset held 24 oscillator periods
// - PLL reset 1us to 10ms; restart 63ms
// - Watchdog reset ends Idle, restart 3 cycles
// - Power-down refused while watchdog enabled
// - Power-down ends by reset or wake irq
// - Port 2 restored from latch in Power-down with external program memory
// - Blocked wake moves Power-down into Idle
// - Wake needs enabled level-sensitive irq held
// - Seconds flag ORed onto ext_irq1 request
module power_mode_control #(
	parameter int RESTART_CYCLES = `PLL_RESTART_MS * 1000000 / `CLK_PERIOD_NS
) (
	input  wire logic SYS_CLK,
	input  wire logic RESETN,
	pwr_if.device     BUS,
	input  wire logic I2C_ENABLE,
	input  wire logic EXT_PROGRAM_MEM,
	input  wire logic EXT_IRQ1_PIN_N,
	input  wire logic SECONDS_FLAG,
	input  wire logic SECONDS_IRQ_EN,
	output logic      BAUD_DOUBLE,
	output logic      AUX_RAM_DISABLE,
	output logic      STROBE_SUPPRESS,
	output logic      GENERAL_FLAG_1,
	output logic      GENERAL_FLAG_0,
	output logic      CORE_CLK_EN,
	output logic      PERIPH_CLK_EN,
	output logic      SLOW_OSC_RUN,
	output logic      HF_OSC_RUN,
	output logic      IDLE_PERIPH_RESET,
	output logic      STROBE_FORCE_EN,
	output logic      STROBE_FORCE_VAL,
	output logic      PWM_FORCE_HIGH,
	output logic      I2C_PINS_HIGHZ,
	output logic      PORT2_FROM_LATCH,
	output logic      PORT0_FLOAT,
	output logic      EXT_IRQ1_REQ_N,
	output logic      RESTART_HOLD
);
	logic [7:0]           ctl_q, ctl_d;
	pwr_pkg::mode_t       mode_q, mode_d;
	logic                 idle_entry_q, idle_entry_d;
	logic [25:0]          restart_q, restart_d;
	logic                 wake_req;
	logic                 reg_wr;

	assign reg_wr   = BUS.sfr_wr && BUS.sfr_addr == `PCTL_ADDR;
	assign wake_req = BUS.ext_irq0_wake || BUS.ext_irq1_wake || BUS.seconds_wake;

	always_comb begin
		ctl_d        = ctl_q;
		mode_d       = mode_q;
		idle_entry_d = 1'b0;
		restart_d    = (restart_q != 26'h0) ? restart_q - 26'h1 : 26'h0;
		if (reg_wr) begin
			ctl_d = BUS.sfr_wdata;
			if (!BUS.watchdog_enable_pin_n)
				ctl_d[`PCTL_POWER_DOWN] = ctl_q[`PCTL_POWER_DOWN];
		end
		if (BUS.wd_counter_load)
			ctl_d[`PCTL_WD_LOAD_EN] = 1'b0;
		case (mode_q)
			pwr_pkg::MODE_RUN: begin
				// Write of idle bit halts core
				if (reg_wr && ctl_d[`PCTL_POWER_DOWN])
					mode_d = pwr_pkg::MODE_PDOWN;
				else if (reg_wr && ctl_d[`PCTL_IDLE]) begin
					mode_d       = pwr_pkg::MODE_IDLE;
					idle_entry_d = 1'b1;
				end
			end
			pwr_pkg::MODE_IDLE: begin
				if (BUS.wake_irq_taken && !BUS.irq_in_service_block) begin
					ctl_d[`PCTL_IDLE] = 1'b0;
					mode_d            = pwr_pkg::MODE_RUN;
				end
			end
			pwr_pkg::MODE_PDOWN: begin
				if (wake_req) begin
					ctl_d[`PCTL_POWER_DOWN] = 1'b0;
					mode_d                  = pwr_pkg::MODE_WAKE;
				end
			end
			pwr_pkg::MODE_WAKE: begin
				if (BUS.irq_in_service_block) begin
					ctl_d[`PCTL_IDLE] = 1'b1;
					mode_d            = pwr_pkg::MODE_IDLE;
					idle_entry_d      = 1'b1;
				end else
					mode_d = pwr_pkg::MODE_RUN;
			end
			default: mode_d = pwr_pkg::MODE_RUN;
		endcase
		// Watchdog reset ends Idle, short restart
		if (BUS.watchdog_reset) begin
			ctl_d     = `PCTL_RESET;
			mode_d    = pwr_pkg::MODE_RUN;
			restart_d = 26'(`WD_RESTART_CYCLES);
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			ctl_q        <= `PCTL_RESET;
			mode_q       <= pwr_pkg::MODE_RUN;
			idle_entry_q <= 1'b0;
			restart_q    <= BUS.osc_source_select ? 26'h0 : 26'(RESTART_CYCLES);
		end else begin
			ctl_q        <= ctl_d;
			mode_q       <= mode_d;
			idle_entry_q <= idle_entry_d;
			restart_q    <= restart_d;
		end
	end

	assign BAUD_DOUBLE     = ctl_q[`PCTL_BAUD_DOUBLE];
	assign AUX_RAM_DISABLE = ctl_q[`PCTL_AUX_RAM_DIS];
	assign STROBE_SUPPRESS = ctl_q[`PCTL_STROBE_SUPP];
	assign GENERAL_FLAG_1  = ctl_q[`PCTL_GFLAG1];
	assign GENERAL_FLAG_0  = ctl_q[`PCTL_GFLAG0];
	assign BUS.sfr_rdata   = ctl_q;
	assign BUS.idle_mode   = mode_q == pwr_pkg::MODE_IDLE;
	assign BUS.pdown_mode  = mode_q == pwr_pkg::MODE_PDOWN;
	// Core frozen in any low-power mode
	assign BUS.core_halted = mode_q != pwr_pkg::MODE_RUN || restart_q != 26'h0;
	assign CORE_CLK_EN     = !BUS.core_halted;
	assign PERIPH_CLK_EN   = mode_q != pwr_pkg::MODE_PDOWN;
	assign HF_OSC_RUN      = BUS.osc_source_select && mode_q != pwr_pkg::MODE_PDOWN;
	assign SLOW_OSC_RUN    = !BUS.osc_source_select && (mode_q != pwr_pkg::MODE_PDOWN || BUS.keep_slow_osc);
	// One-cycle reset pulse on Idle entry
	assign IDLE_PERIPH_RESET = idle_entry_q;
	assign STROBE_FORCE_EN  = mode_q == pwr_pkg::MODE_IDLE || mode_q == pwr_pkg::MODE_PDOWN;
	assign STROBE_FORCE_VAL = mode_q == pwr_pkg::MODE_IDLE;
	assign PWM_FORCE_HIGH   = STROBE_FORCE_EN;
	assign PORT0_FLOAT      = STROBE_FORCE_EN && EXT_PROGRAM_MEM;
	// I2C pins float in Power-down, and in Idle unless enabled
	assign I2C_PINS_HIGHZ   = mode_q == pwr_pkg::MODE_PDOWN || (mode_q == pwr_pkg::MODE_IDLE && !I2C_ENABLE);
	// Port 2 shows latch in Power-down with external program memory
	assign PORT2_FROM_LATCH = mode_q == pwr_pkg::MODE_PDOWN && EXT_PROGRAM_MEM;
	assign EXT_IRQ1_REQ_N   = EXT_IRQ1_PIN_N && !(SECONDS_FLAG && SECONDS_IRQ_EN);
	assign RESTART_HOLD     = restart_q != 26'h0;
endmodule

// ===== rtl/power_core_end.sv
`timescale 1ns/1ns
`include "pwr_regs.svh"
// Core-side end: issues register writes and relays interrupt status.
module power_core_end (
	input  wire logic       SYS_CLK,
	input  wire logic       RESETN,
	pwr_if.core             BUS,
	input  wire logic       WR_REQ,
	input  wire logic [7:0] WR_DATA,
	input  wire logic       WD_LOAD_REQ,
	input  wire logic       WD_ENABLE_N,
	input  wire logic       OSC_SELECT,
	input  wire logic       KEEP_SLOW,
	input  wire logic       BLOCKED,
	input  wire logic       IRQ0_WAKE,
	input  wire logic       IRQ1_WAKE,
	input  wire logic       SEC_WAKE,
	input  wire logic       IRQ_TAKEN,
	input  wire logic       WD_RESET,
	output logic [7:0]      RD_DATA,
	output logic            HALTED
);
	logic [7:0] rd_q, rd_d;
	logic       wd_ok_q, wd_ok_d;

	always_comb begin
		rd_d    = BUS.sfr_rdata;
		wd_ok_d = wd_ok_q;
		if (WR_REQ && !BUS.core_halted)
			wd_ok_d = WR_DATA[`PCTL_WD_LOAD_EN];
		if (BUS.wd_counter_load)
			wd_ok_d = 1'b0;
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESETN) begin
			rd_q    <= 8'h00;
			wd_ok_q <= 1'b0;
		end else begin
			rd_q    <= rd_d;
			wd_ok_q <= wd_ok_d;
		end
	end

	// Writes are dropped while halted: the core executes nothing then
	assign BUS.sfr_wr                = WR_REQ && !BUS.core_halted;
	assign BUS.sfr_addr              = `PCTL_ADDR;
	assign BUS.sfr_wdata             = WR_DATA;
	assign BUS.wd_counter_load       = WD_LOAD_REQ && wd_ok_q;
	assign BUS.watchdog_enable_pin_n = WD_ENABLE_N;
	assign BUS.osc_source_select     = OSC_SELECT;
	assign BUS.keep_slow_osc         = KEEP_SLOW;
	assign BUS.irq_in_service_block  = BLOCKED;
	assign BUS.ext_irq0_wake         = IRQ0_WAKE;
	assign BUS.ext_irq1_wake         = IRQ1_WAKE;
	assign BUS.seconds_wake          = SEC_WAKE;
	assign BUS.wake_irq_taken        = IRQ_TAKEN;
	assign BUS.watchdog_reset        = WD_RESET;
	assign RD_DATA                   = rd_q;
	assign HALTED                    = BUS.core_halted;
endmodule

// ===== test/pwr_mode_asserts.sv
`timescale 1ns/1ns
module pwr_mode_asserts (
	input logic       SYS_CLK,
	input logic       RESETN,
	input logic       sfr_wr,
	input logic [7:0] sfr_addr,
	input logic [7:0] sfr_wdata,
	input logic [7:0] sfr_rdata,
	input logic       wd_counter_load,
	input logic       watchdog_enable_pin_n,
	input logic       irq_in_service_block,
	input logic       ext_irq0_wake,
	input logic       wake_irq_taken,
	input logic       watchdog_reset,
	input logic       core_halted,
	input logic       idle_mode,
	input logic       pdown_mode
);
	logic take;
	assign take = sfr_wr && sfr_addr == 8'h87 && !core_halted;
	default clocking dc @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);
	chk_reset_zero: assert property ($rose(RESETN) |-> sfr_rdata == 8'h00) else $error("bad reset value");
	chk_write_echo: assert property (take && !sfr_wdata[1] && !wd_counter_load && !watchdog_reset
		|=> sfr_rdata == $past(sfr_wdata)) else $error("write not held");
	chk_pd_refused: assert property (take && sfr_wdata[1] && !watchdog_enable_pin_n
		|=> !pdown_mode && !sfr_rdata[1]) else $error("power-down taken");
	chk_idle_entry: assert property (take && sfr_wdata[1:0] == 2'b01 && !watchdog_reset
		|=> idle_mode && core_halted) else $error("idle not entered");
	chk_wle_clear: assert property (wd_counter_load && !take |=> !sfr_rdata[4]) else $error("load flag kept");
	chk_idle_exit: assert property (idle_mode && !pdown_mode && wake_irq_taken && !irq_in_service_block
		|=> !idle_mode && !sfr_rdata[0]) else $error("idle not left");
	chk_idle_hold: assert property (idle_mode && wake_irq_taken && irq_in_service_block && !watchdog_reset
		&& !take |=> idle_mode) else $error("blocked wake left idle");
	chk_wd_restart: assert property (watchdog_reset |=> sfr_rdata == 8'h00 ##[0:3] !core_halted)
		else $error("watchdog restart");
	chk_pd_wake: assert property (pdown_mode && ext_irq0_wake |-> ##[1:2] !pdown_mode)
		else $error("no wake");
endmodule

// ===== test/test_power_mode_control.sv
`timescale 1ns/1ns
module test_power_mode_control;
	logic        clk = 0, rstn = 0, wr = 0, wdl = 0, wden_n = 1, blk = 0, i0 = 0, tk = 0, wdr = 0;
	logic        i2c = 0, extp = 0, pin_n = 1, sf = 0, se = 0, look = 0;
	logic [7:0]  wdat = 0, rd, v;
	logic [4:0]  ob;
	logic [12:0] m;
	logic [7:0]  q[$];
	int          n_errors = 0, num_checks = 0, i;
	pwr_if bus ();
	power_mode_control #(.RESTART_CYCLES(20)) power_mode_control_inst (.SYS_CLK(clk), .RESETN(rstn), .BUS(bus),
		.I2C_ENABLE(i2c), .EXT_PROGRAM_MEM(extp), .EXT_IRQ1_PIN_N(pin_n), .SECONDS_FLAG(sf), .SECONDS_IRQ_EN(se),
		.BAUD_DOUBLE(ob[4]), .AUX_RAM_DISABLE(ob[3]), .STROBE_SUPPRESS(ob[2]), .GENERAL_FLAG_1(ob[1]),
		.GENERAL_FLAG_0(ob[0]), .CORE_CLK_EN(m[12]), .PERIPH_CLK_EN(m[11]), .SLOW_OSC_RUN(m[10]),
		.HF_OSC_RUN(m[9]), .IDLE_PERIPH_RESET(m[8]), .STROBE_FORCE_EN(m[7]), .STROBE_FORCE_VAL(m[6]),
		.PWM_FORCE_HIGH(m[5]), .I2C_PINS_HIGHZ(m[4]), .PORT2_FROM_LATCH(m[3]), .PORT0_FLOAT(m[2]),
		.EXT_IRQ1_REQ_N(m[1]), .RESTART_HOLD(m[0]));
	power_core_end power_core_end_inst (.SYS_CLK(clk), .RESETN(rstn), .BUS(bus), .WR_REQ(wr), .WR_DATA(wdat),
		.WD_LOAD_REQ(wdl), .WD_ENABLE_N(wden_n), .OSC_SELECT(1'b1), .KEEP_SLOW(1'b0), .BLOCKED(blk),
		.IRQ0_WAKE(i0), .IRQ1_WAKE(1'b0), .SEC_WAKE(1'b0), .IRQ_TAKEN(tk), .WD_RESET(wdr), .RD_DATA(rd),
		.HALTED());
	pwr_mode_asserts asserts_inst (.SYS_CLK(clk), .RESETN(rstn), .sfr_wr(bus.sfr_wr), .sfr_addr(bus.sfr_addr),
		.sfr_wdata(bus.sfr_wdata), .sfr_rdata(bus.sfr_rdata), .wd_counter_load(bus.wd_counter_load),
		.watchdog_enable_pin_n(bus.watchdog_enable_pin_n), .irq_in_service_block(bus.irq_in_service_block),
		.ext_irq0_wake(bus.ext_irq0_wake), .wake_irq_taken(bus.wake_irq_taken),
		.watchdog_reset(bus.watchdog_reset), .core_halted(bus.core_halted), .idle_mode(bus.idle_mode),
		.pdown_mode(bus.pdown_mode));
	always #20 clk = ~clk;
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic close_out();
		if (n_errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic wrt(input logic [7:0] d);
		@(negedge clk) wr = 1;
		wdat = d;
		@(negedge clk) wr = 0;
	endtask
	// Read-back lands one edge after the write edge
	task automatic rdb(input logic [7:0] e);
		q.push_back(e);
		@(negedge clk) look <= 1;
		@(negedge clk) look <= 0;
	endtask
	always @(negedge clk) begin
		if (look) begin
			chk({8'h00, rd}, {8'h00, q.pop_front()});
		end
	end
	initial begin
		void'($urandom(32'h722d471b));
		// reset held for 16 clock cycles
		repeat (16) @(negedge clk);
		rstn = 1;
		rdb(8'h00);
		chk({11'h0, ob}, 16'h0000);
		for (i = 0; i < 4; i++) begin
			v = 8'($urandom) & 8'hfc;
			wrt(v);
			rdb(v);
			chk({11'h0, ob}, {11'h0, v[7:5], v[3:2]});
		end
		wrt(8'h10);
		@(negedge clk) wdl = 1;
		@(negedge clk) wdl = 0;
		rdb(8'h00);
		wden_n = 0;
		wrt(8'h02);
		rdb(8'h00);
		chk({15'h0, bus.pdown_mode}, 16'h0000);
		wden_n = 1;
		{i2c, extp} = 2'($urandom);
		wrt(8'h05);
		chk({14'h0, bus.idle_mode, bus.core_halted}, 16'h0003);
		// Entry pulse rises on the same edge as the mode
		chk({15'h0, m[8]}, 16'h0001);
		@(negedge clk);
		chk({15'h0, m[8]}, 16'h0000);
		chk({14'h0, m[10], m[0]}, 16'h0000);
		chk({6'h0, m[12:11], m[9:2]}, {6'h0, 4'b0110, 3'b111, !i2c, 1'b0, extp});
		// Wake is held off while an equal level is in service
		blk = 1;
		tk = 1;
		repeat (3) @(negedge clk);
		chk({15'h0, bus.idle_mode}, 16'h0001);
		blk = 0;
		repeat (2) @(negedge clk);
		tk = 0;
		chk({15'h0, bus.idle_mode}, 16'h0000);
		rdb(8'h04);
		wrt(8'h02);
		@(negedge clk);
		chk({6'h0, bus.pdown_mode, m[12:11], m[9], m[7:2]}, {6'h0, 7'b1000101, 1'b1, extp, extp});
		// wake level held until the mode is left
		i0 = 1;
		for (i = 0; i < 10 && bus.pdown_mode === 1'b1; i++) begin
			@(negedge clk);
		end
		i0 = 0;
		chk({15'h0, bus.pdown_mode}, 16'h0000);
		wrt(8'h81);
		@(negedge clk) wdr = 1;
		@(negedge clk) wdr = 0;
		rdb(8'h00);
		chk({15'h0, bus.idle_mode}, 16'h0000);
		for (i = 0; i < 8; i++) begin
			@(negedge clk) {pin_n, sf, se} = 3'(i);
			#1 chk({15'h0, m[1]}, {15'h0, pin_n && !(sf && se)});
		end
		close_out();
	end
	initial begin
		#200000;
		n_errors++;
		close_out();
	end
endmodule
